// ### design/sld_cfg.svh
/*
 Constants of the segment LCD driver: register offsets, field positions,
 masks, drive levels and timing. Assumes a 200 MHz reference clock.
*/
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH
`define SLD_SEGS 60
`define SLD_COMS 9
`define SLD_LVW 3
`define SLD_AW 8
`define SLD_OFS_CTRL 8'h00
`define SLD_OFS_ADDR 8'h04
`define SLD_OFS_DATA 8'h08
`define SLD_OFS_BIAS 8'h0c
`define SLD_HI_RAM 7'h40
`define SLD_B_DUTY 0
`define SLD_B_CLO 1
`define SLD_B_CHI 2
`define SLD_B_VLO 2
`define SLD_B_VHI 4
`define SLD_CTRL_MASK 8'h07
`define SLD_BIAS_MASK 8'hfd
`define SLD_IDX_MASK 8'h7f
`define SLD_RESP_OK 2'b00
`define SLD_RESP_ERR 2'b10
`define SLD_LV0 3'h0
`define SLD_LV1 3'h1
`define SLD_LV2 3'h2
`define SLD_LV3 3'h3
`define SLD_LV4 3'h4
`define SLD_COM_LAST8 4'h7
`define SLD_COM_LAST9 4'h8
`define SLD_CLK_HZ 200000000
`define SLD_BASE_HZ 32768
`define SLD_BASE_DIV (`SLD_CLK_HZ / `SLD_BASE_HZ)
`define SLD_SCAN_DIV 64
`endif

// ### design/sld_pkg.sv
/*
 Types of the segment LCD driver: display state and the state record.
 Assumes sld_cfg.svh is on the include path.
*/
`include "sld_cfg.svh"
package sld_pkg;
   typedef enum logic [2:0]
   {
      ST_OFF = 3'b001,
      ST_BLANK = 3'b010,
      ST_ON = 3'b100
   } sld_disp_t;

   typedef struct packed {
      sld_disp_t st;
      logic duty8;
      logic [7:0] ctrl;
      logic [6:0] idx;
      logic [7:0] bias;
      logic awrdy;
      logic wrdy;
      logic [7:0] awa;
      logic [7:0] wd;
      logic ws;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [15:0] bdiv;
      logic [7:0] sdiv;
      logic [3:0] com;
      logic pol;
      logic lcd_on;
      logic [`SLD_COMS-1:0] com_en;
      logic [`SLD_COMS*`SLD_LVW-1:0] cl;
      logic [`SLD_SEGS*`SLD_LVW-1:0] seg;
   } sld_state_t;

   localparam sld_state_t SLD_RST = '{st: ST_OFF, awrdy: 1'b1,
      wrdy: 1'b1, arrdy: 1'b1, default: '0};
endpackage

// ### design/sld_top.sv
/*
 Segment LCD driver: AXI4-Lite register slave, 128-byte display RAM and
 a 1/4-bias multiplexed scanner for 60 segments and 9 commons.
 Assumes an external analog stage turns level codes 0..4 into V0..V4
 and the drive-voltage code into the LCD supply.
*/
// Function
// - Drive sixty segment lines and nine common lines directly.
// - Duty bit: zero gives 1/9, one gives 1/8; bias always 1/4.
// - Control code 11 enables, 01 blanks, 10 only changes duty.
// - Code 00 turns off with duty bit one, else only changes duty.
// - Address register holds seven bits; bit 7 reads zero.
// - Address register is write-only while display enabled.
// - Data register reads and writes RAM byte at current address.
// - Segment n takes commons 0..7 from RAM byte n.
// - In 1/9 duty ninth common data comes from byte 40h plus n.
// - 1/8 duty leaves ninth common open; 1/9 scans all nine.
// - RAM bit one gives select waveform, zero gives non-select.
// - Scan timing derives from the 32.768 kHz base clock.
// - Bias register bits 2..4 choose one of eight drive voltages.
module sld_top
   import sld_pkg::*;
#(
   parameter int BASE_DIV = `SLD_BASE_DIV,
   parameter int SCAN_DIV = `SLD_SCAN_DIV
)
(
   input wire logic i_ref_clk, // 200 MHz clock
   input wire logic i_rst_n, // Sync reset, active low
   input wire logic i_awvalid, // Write address valid
   output logic o_awready, // Write address ready
   input wire logic [`SLD_AW-1:0] i_awaddr, // Write byte address
   input wire logic i_wvalid, // Write data valid
   output logic o_wready, // Write data ready
   input wire logic [31:0] i_wdata, // Write data
   input wire logic [3:0] i_wstrb, // Byte enables
   output logic o_bvalid, // Write response valid
   input wire logic i_bready, // Write response ready
   output logic [1:0] o_bresp, // Write response
   input wire logic i_arvalid, // Read address valid
   output logic o_arready, // Read address ready
   input wire logic [`SLD_AW-1:0] i_araddr, // Read byte address
   output logic o_rvalid, // Read data valid
   input wire logic i_rready, // Read data ready
   output logic [31:0] o_rdata, // Read data
   output logic [1:0] o_rresp, // Read response
   output logic [`SLD_SEGS*`SLD_LVW-1:0] o_seg_lvl, // Segment levels
   output logic [`SLD_COMS*`SLD_LVW-1:0] o_com_lvl, // Common levels
   output logic [`SLD_COMS-1:0] o_com_en, // Common driven, else open
   output logic [2:0] o_vop_sel, // Drive voltage code
   output logic o_lcd_on // Panel powered
);

////////////////////////////////////////////////////////////////////////
   sld_state_t s;
   sld_state_t s_nxt;
   logic [7:0] ram [128];
   logic ram_we;
   logic [7:0] ram_rd;
   logic wr_go;
   logic step;
   logic [3:0] last;
   logic bit_v;

   function automatic logic [2:0] com_lvl(input logic sel, input logic pol);
      if (sel)
      begin
         return pol ? `SLD_LV0 : `SLD_LV4;
      end
      return pol ? `SLD_LV3 : `SLD_LV1;
   endfunction

   function automatic logic [2:0] seg_lvl(input logic on, input logic pol);
      if (on)
      begin
         return pol ? `SLD_LV4 : `SLD_LV0;
      end
      return `SLD_LV2;
   endfunction

////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_nxt = s;
      ram_we = 1'b0;
      wr_go = 1'b0;
      step = 1'b0;
      bit_v = 1'b0;
      ram_rd = ram[s.idx];
      // Address and data are taken independently, in either order
      if (i_awvalid && s.awrdy)
      begin
         s_nxt.awa = i_awaddr;
         s_nxt.awrdy = 1'b0;
      end
      if (i_wvalid && s.wrdy)
      begin
         s_nxt.wd = i_wdata[7:0];
         s_nxt.ws = i_wstrb[0];
         s_nxt.wrdy = 1'b0;
      end
      if (!s.awrdy && !s.wrdy && !s.bvalid)
      begin
         wr_go = 1'b1;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `SLD_RESP_OK;
         case (s.awa)
            `SLD_OFS_CTRL:
            begin
               if (s.ws)
               begin
                  s_nxt.ctrl = s.wd & `SLD_CTRL_MASK;
                  s_nxt.duty8 = s.wd[`SLD_B_DUTY];
                  unique case ({s.wd[`SLD_B_CHI], s.wd[`SLD_B_CLO]})
                     2'b11: s_nxt.st = ST_ON;
                     2'b01: s_nxt.st = ST_BLANK;
                     2'b00:
                     begin
                        if (s.wd[`SLD_B_DUTY])
                        begin
                           s_nxt.st = ST_OFF;
                        end
                     end
                     2'b10: s_nxt.st = s.st;
                  endcase
               end
            end
            `SLD_OFS_ADDR:
            begin
               if (s.ws)
               begin
                  s_nxt.idx = s.wd[6:0];
               end
            end
            `SLD_OFS_DATA: ram_we = s.ws;
            `SLD_OFS_BIAS:
            begin
               if (s.ws)
               begin
                  s_nxt.bias = s.wd & `SLD_BIAS_MASK;
               end
            end
            default: s_nxt.bresp = `SLD_RESP_ERR;
         endcase
      end
      if (s.bvalid && i_bready)
      begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awrdy = 1'b1;
         s_nxt.wrdy = 1'b1;
      end
      // Read answers at the edge that takes the address
      if (i_arvalid && s.arrdy)
      begin
         s_nxt.arrdy = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `SLD_RESP_OK;
         s_nxt.rdata = '0;
         case (i_araddr)
            `SLD_OFS_CTRL: s_nxt.rdata[7:0] = s.ctrl;
            `SLD_OFS_ADDR:
            begin
               if (s.st != ST_ON)
               begin
                  s_nxt.rdata[7:0] = {1'b0, s.idx};
               end
            end
            `SLD_OFS_DATA: s_nxt.rdata[7:0] = ram_rd;
            `SLD_OFS_BIAS: s_nxt.rdata[7:0] = s.bias;
            default: s_nxt.rresp = `SLD_RESP_ERR;
         endcase
      end
      if (s.rvalid && i_rready)
      begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arrdy = 1'b1;
      end
      // Base tick, then one scan step per SCAN_DIV base ticks
      s_nxt.bdiv = s.bdiv + 16'h0001;
      if (s.bdiv == 16'(BASE_DIV - 1))
      begin
         s_nxt.bdiv = '0;
         s_nxt.sdiv = s.sdiv + 8'h01;
         if (s.sdiv == 8'(SCAN_DIV - 1))
         begin
            s_nxt.sdiv = '0;
            step = 1'b1;
         end
      end
      last = s.duty8 ? `SLD_COM_LAST8 : `SLD_COM_LAST9;
      // Polarity flips per frame so the glass sees no DC
      if (step)
      begin
         if (s.com >= last)
         begin
            s_nxt.com = '0;
            s_nxt.pol = ~s.pol;
         end
         else
         begin
            s_nxt.com = s.com + 4'h1;
         end
      end
      for (int c = 0; c < `SLD_COMS; c++)
      begin
         s_nxt.com_en[c] = (s.st != ST_OFF) && (4'(c) <= last);
         s_nxt.cl[c*`SLD_LVW +: `SLD_LVW] = s_nxt.com_en[c] ?
            com_lvl(4'(c) == s.com, s.pol) : `SLD_LV0;
      end
      for (int g = 0; g < `SLD_SEGS; g++)
      begin
         if (s.com == `SLD_COM_LAST9)
         begin
            bit_v = ram[7'(`SLD_HI_RAM + 7'(g))][0];
         end
         else
         begin
            bit_v = ram[7'(g)][s.com[2:0]];
         end
         // Blanking forces non-select whatever the RAM holds
         s_nxt.seg[g*`SLD_LVW +: `SLD_LVW] = (s.st == ST_OFF) ?
            `SLD_LV0 : seg_lvl(bit_v && s.st == ST_ON, s.pol);
      end
      // Registered copy so the pin follows the state with no gate behind it
      s_nxt.lcd_on = (s_nxt.st != ST_OFF);
   end

////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         s <= SLD_RST;
      end
      else
      begin
         s <= s_nxt;
      end
   end

   // RAM is not reset; software loads it before enabling the display
   always_ff @(posedge i_ref_clk)
   begin
      if (ram_we)
      begin
         ram[s.idx] <= s.wd;
      end
   end

   assign o_awready = s.awrdy;
   assign o_wready = s.wrdy;
   assign o_bvalid = s.bvalid;
   assign o_bresp = s.bresp;
   assign o_arready = s.arrdy;
   assign o_rvalid = s.rvalid;
   assign o_rdata = s.rdata;
   assign o_rresp = s.rresp;
   assign o_seg_lvl = s.seg;
   assign o_com_lvl = s.cl;
   assign o_com_en = s.com_en;
   assign o_vop_sel = s.bias[`SLD_B_VHI:`SLD_B_VLO];
   assign o_lcd_on = s.lcd_on;

////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   chk_ninth_common_line_open: assert property (
      s.duty8 |=> !o_com_en[`SLD_COMS-1])
      else $error("ninth common driven in 1/8 duty");
   chk_off_quiet: assert property (
      s.st == ST_OFF ##1 s.st == ST_OFF |-> o_seg_lvl == '0 &&
      o_com_lvl == '0 && !o_lcd_on)
      else $error("lines not quiet while off");
   chk_blank_nonsel: assert property (
      s.st == ST_BLANK |=> o_seg_lvl == {`SLD_SEGS{`SLD_LV2}})
      else $error("segment selected while blanked");
   chk_scan_wrap: assert property (
      step && s.com >= last |=> s.com == 4'h0 && s.pol != $past(s.pol))
      else $error("scan did not wrap with polarity flip");
   chk_addr_hidden: assert property (
      i_arvalid && s.arrdy && i_araddr == `SLD_OFS_ADDR && s.st == ST_ON
      |=> o_rvalid && o_rdata == 32'h0000_0000)
      else $error("address readable while enabled");
   chk_ctrl_zeros: assert property (
      i_arvalid && s.arrdy && i_araddr == `SLD_OFS_CTRL
      |=> o_rdata[3] == 1'b0 && o_rdata[31:7] == '0)
      else $error("control unused bits not zero");
   chk_vop_write: assert property (
      wr_go && s.awa == `SLD_OFS_BIAS && s.ws
      |=> o_vop_sel == $past(s.wd[`SLD_B_VHI:`SLD_B_VLO]))
      else $error("drive voltage not taken");
   chk_no_autoinc: assert property (
      wr_go && s.awa == `SLD_OFS_DATA |=> $stable(s.idx))
      else $error("address moved after data write");
   chk_resp_hold: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");

   cov_enable: cover property (s.st == ST_OFF ##1 s.st == ST_ON);
   cov_blank: cover property (s.st == ST_BLANK && step);
   cov_ninth: cover property (step && s.com == `SLD_COM_LAST9);
   cov_ram_wr: cover property (ram_we);
endmodule

// ### testbench/sld_panel.sv
/*
 Passive multiplexed LCD glass seen by the segment LCD driver bench.
 Assumes the driver's level codes 0..4 and one selected common at a time.
*/
`include "sld_cfg.svh"
module sld_panel
(
   input wire logic [`SLD_SEGS*`SLD_LVW-1:0] i_seg_lvl, // Segment levels
   input wire logic [`SLD_COMS*`SLD_LVW-1:0] i_com_lvl, // Common levels
   input wire logic [`SLD_COMS-1:0] i_com_en, // Commons driven
   output logic [`SLD_COMS-1:0] o_sel, // Commons at select level
   output logic [`SLD_SEGS-1:0] o_lit // Dots lit on selected common
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] sel_lvl;
   always_comb
   begin
      o_sel = '0;
      sel_lvl = 3'h2;
      for (int c = 0; c < `SLD_COMS; c++)
      begin
         // An open common puts no field across the glass
         if (i_com_en[c] && i_com_lvl[3*c +: 3] inside {3'h0, 3'h4})
         begin
            o_sel[c] = 1'b1;
            sel_lvl = i_com_lvl[3*c +: 3];
         end
      end
      // Only the full four-level swing lights a dot
      for (int n = 0; n < `SLD_SEGS; n++)
         o_lit[n] = (|o_sel) && (i_seg_lvl[3*n +: 3] == 3'h4 - sel_lvl);
   end
endmodule

// ### testbench/testbench.sv
/*
 Self-checking bench of the segment LCD driver: registers over AXI4-Lite,
 scan checked through the panel model. Assumes short scan dividers.
*/
`include "sld_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdat;
   logic awr, wrdy, bv, arr, rv, on;
   logic [1:0] bresp, rresp;
   logic [179:0] seg;
   logic [26:0] coml;
   logic [8:0] cen, sel;
   logic [2:0] vop;
   logic [59:0] lit;
   int num_errors = 0, check_count = 0;
   logic [7:0] lo [2] = '{8'ha5, 8'h5a};
   logic hi [2] = '{1'b1, 1'b0};
   int sg [2] = '{5, 59};
   always #2.5 clk = ~clk;
   sld_top #(.BASE_DIV(2), .SCAN_DIV(2)) sld_top_inst (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_awvalid(awv), .o_awready(awr),
      .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd),
      .i_wstrb(4'h1), .o_bvalid(bv), .i_bready(bry), .o_bresp(bresp),
      .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
      .i_rready(rry), .o_rdata(rdat), .o_rresp(rresp), .o_seg_lvl(seg),
      .o_com_lvl(coml), .o_com_en(cen), .o_vop_sel(vop), .o_lcd_on(on));
   sld_panel sld_panel_inst (.i_seg_lvl(seg), .i_com_lvl(coml),
      .i_com_en(cen), .o_sel(sel), .o_lit(lit));
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   // Bounded wait for the slave's answer
   task automatic tick(inout int k);
      @(posedge clk);
      k++;
      if (k > 60)
      begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] a, d, input logic [1:0] e = 2'b00);
      int k = 0;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {24'h0, d};
      bry <= 1'b1;
      while (1)
      begin
         tick(k);
         if (awr)
            awv <= 1'b0;
         if (wrdy)
            wv <= 1'b0;
         if (bv === 1'b1)
            break;
      end
      bry <= 1'b0;
      chk("bresp", {30'h0, e}, {30'h0, bresp});
   endtask
   task automatic rd(input logic [7:0] a, d, input logic [1:0] e = 2'b00);
      int k = 0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      while (1)
      begin
         tick(k);
         if (arr)
            arv <= 1'b0;
         if (rv === 1'b1)
            break;
      end
      rry <= 1'b0;
      chk("rdata", {24'h0, d}, rdat);
      chk("rresp", {30'h0, e}, {30'h0, rresp});
   endtask
   // Skips a few steps first: a duty change takes effect at the next step
   task automatic scan(input logic blank, input logic [8:0] exp);
      logic [8:0] seen;
      seen = '0;
      repeat (8) @(posedge clk);
      chk("com_en", {23'h0, exp}, {23'h0, cen});
      repeat (48)
      begin
         @(posedge clk);
         seen |= sel;
         for (int c = 0; c < 9; c++)
            if (sel[c])
               for (int i = 0; i < 2; i++)
                  chk("lit", {31'h0, (c < 8 ? lo[i][c] : hi[i]) & !blank},
                     {31'h0, lit[sg[i]]});
      end
      chk("commons", {23'h0, exp}, {23'h0, seen});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`SLD_OFS_CTRL, 8'h00);
      rd(`SLD_OFS_BIAS, 8'h00);
      rd(`SLD_OFS_ADDR, 8'h00);
      wr(`SLD_OFS_CTRL, 8'hf9);
      rd(`SLD_OFS_CTRL, 8'h01);
      chk("lcd_on", 32'h0, {31'h0, on});
      wr(`SLD_OFS_BIAS, 8'hff);
      rd(`SLD_OFS_BIAS, 8'hfd);
      for (int v = 0; v < 8; v++)
      begin
         wr(`SLD_OFS_BIAS, 8'(v << 2));
         chk("vop_sel", 32'(v), {29'h0, vop});
      end
      wr(`SLD_OFS_ADDR, 8'hff);
      rd(`SLD_OFS_ADDR, 8'h7f);
      wr(8'h10, 8'h55, 2'b10);
      rd(8'h10, 8'h00, 2'b10);
      for (int i = 0; i < 2; i++)
      begin
         wr(`SLD_OFS_ADDR, 8'(sg[i]));
         wr(`SLD_OFS_DATA, lo[i]);
         wr(`SLD_OFS_ADDR, 8'(8'h40 + sg[i]));
         wr(`SLD_OFS_DATA, {7'h0, hi[i]});
      end
      wr(`SLD_OFS_ADDR, 8'h05);
      rd(`SLD_OFS_DATA, 8'ha5);
      rd(`SLD_OFS_DATA, 8'ha5);
      rd(`SLD_OFS_ADDR, 8'h05);
      wr(`SLD_OFS_CTRL, 8'h06);
      rd(`SLD_OFS_ADDR, 8'h00);
      scan(1'b0, 9'h1ff);
      wr(`SLD_OFS_ADDR, 8'h05);
      wr(`SLD_OFS_DATA, 8'h3c);
      rd(`SLD_OFS_DATA, 8'h3c);
      lo[0] = 8'h3c;
      wr(`SLD_OFS_CTRL, 8'h04);
      scan(1'b0, 9'h1ff);
      wr(`SLD_OFS_CTRL, 8'h07);
      scan(1'b0, 9'h0ff);
      wr(`SLD_OFS_CTRL, 8'h03);
      scan(1'b1, 9'h0ff);
      wr(`SLD_OFS_CTRL, 8'h00);
      scan(1'b1, 9'h1ff);
      wr(`SLD_OFS_CTRL, 8'h01);
      chk("lcd_on", 32'h0, {31'h0, on});
      // Lines are registered one clock after the state turns off
      repeat (2) @(posedge clk);
      chk("com_en", 32'h0, {23'h0, cen});
      chk("seg_any", 32'h0, {31'h0, |seg});
      summarize();
   end
endmodule
